// [logic/ebsd_lane_decode.sv]
// Byte-lane decoder for one external access.
// Pure combinational; driven from the same clock domain as its user.
`timescale 1ns/1ps
`default_nettype none
module ebsd_lane_decode
    import ebsd_pkg::*;
(
    input  wire ebsd_pkg::ebsd_width_e width,
    input  wire ebsd_pkg::ebsd_size_e  size,
    input  wire logic [1:0]            addr_lo,
    output logic [3:0]                 lanes
);
    // Lane 3 is D31-D24; lower addresses sit on higher lanes
    function automatic logic [3:0] lane_mask(input ebsd_width_e w,
                                             input ebsd_size_e  s,
                                             input logic [1:0]  a);
        logic [3:0] m;
        m = EBSD_LANES_NONE;
        case (w)
            EBSD_BW_8: m = 4'h1;
            EBSD_BW_16: begin
                if (s == EBSD_SZ_BYTE) m = a[0] ? 4'h1 : 4'h2;
                else                   m = 4'h3;
            end
            EBSD_BW_32: begin
                case (s)
                    EBSD_SZ_BYTE: m = 4'h8 >> a;
                    EBSD_SZ_WORD: m = a[1] ? 4'h3 : 4'hC;
                    default:      m = EBSD_LANES_ALL;
                endcase
            end
            default: m = EBSD_LANES_NONE; // Reserved width drives nothing
        endcase
        return m;
    endfunction

    // Pattern picked from width, size and low address bits (see RULE12)
    always_comb begin
        lanes = lane_mask(width, size, addr_lo);
    end
endmodule
`default_nettype wire

// [logic/ebsd_pkg.sv]
// Shared constants and types for the external bus strobe decoder.
// Assumes one bus clock domain; all users import ebsd_pkg::*.
`default_nettype none
package ebsd_pkg;

    // Kind of space that an internal bus access targets
    typedef enum logic [1:0] {
        EBSD_SP_ROM    = 2'b00,
        EBSD_SP_RAM    = 2'b01,
        EBSD_SP_PERIPH = 2'b10,
        EBSD_SP_EXT    = 2'b11
    } ebsd_space_e;

    // Memory type configured for one chip-select area
    typedef enum logic [1:0] {
        EBSD_MT_NORMAL  = 2'b00,
        EBSD_MT_BYTESEL = 2'b01,
        EBSD_MT_RSVD2   = 2'b10,
        EBSD_MT_RSVD3   = 2'b11
    } ebsd_memtype_e;

    // Data bus width configured for one chip-select area
    typedef enum logic [1:0] {
        EBSD_BW_8    = 2'b00,
        EBSD_BW_16   = 2'b01,
        EBSD_BW_32   = 2'b10,
        EBSD_BW_RSVD = 2'b11
    } ebsd_width_e;

    // Access size from the bus master
    typedef enum logic [1:0] {
        EBSD_SZ_BYTE = 2'b00,
        EBSD_SZ_WORD = 2'b01,
        EBSD_SZ_LONG = 2'b10,
        EBSD_SZ_RSVD = 2'b11
    } ebsd_size_e;

    localparam int EBSD_ADDR_W = 26;
    localparam int EBSD_DATA_W = 32;
    localparam int EBSD_LANES  = 4;
    localparam int EBSD_NUM_CS = 8;
    localparam int EBSD_CFG_W  = 2;

    // Reset and idle values of the pins
    localparam logic                   EBSD_STROBE_IDLE = 1'b1;
    localparam logic                   EBSD_PIN_DRIVE   = 1'b1;
    localparam logic [7:0]             EBSD_CS_IDLE     = 8'hFF;
    localparam logic [7:0]             EBSD_CS_ONE      = 8'h01;
    localparam logic [3:0]             EBSD_LANES_NONE  = 4'h0;
    localparam logic [3:0]             EBSD_LANES_ALL   = 4'hF;
    localparam logic [1:0]             EBSD_PAIR_IDLE   = 2'h3;
    localparam logic [EBSD_ADDR_W-1:0] EBSD_ADDR_RST    = 26'h0000000;
    localparam logic [EBSD_DATA_W-1:0] EBSD_DATA_RST    = 32'h00000000;

    // Two-bit configuration field of area idx inside a packed vector
    function automatic logic [1:0] ebsd_cfg_field(input logic [15:0] vec,
                                                  input logic [2:0]  idx);
        ebsd_cfg_field = vec[{idx, 1'b0} +: 2];
    endfunction

endpackage
`default_nettype wire

// [logic/ebsd_strobe_ctrl.sv]
// External bus strobe decoder: chip selects, read/write strobes,
// byte strobes, address hold and data lane enables per access.
// Assumes the bus master sits on mclk, holds acc_* stable while
// acc_valid is high, and supplies write data already lane aligned.
`timescale 1ns/1ps
`default_nettype none
// Function
// (RULE1) Internal ROM, RAM, peripheral access: all strobes high, data bus floated.
// (RULE2) Internal access keeps the last external address on the address pins.
// (RULE3) External access: addressed chip select low, others high, cycle strobe low.
// (RULE4) Normal space: read strobe low on reads, direction low on writes.
// (RULE5) 8-bit writes use lowest strobe; 16-bit writes strobe addressed bytes.
// (RULE6) 32-bit writes strobe each addressed lane; reads keep write strobes high.
// (RULE7) Data drives only addressed lanes; unused lanes float.
// (RULE8) 16-bit byte-select SRAM strobes bytes on reads and writes alike.
// (RULE9) 32-bit byte-select SRAM strobes addressed lanes on reads and writes.
// (RULE10) In standby, retained outputs float when the float bit is set.
// (RULE11) In standby, floating control pins are driven when override bits are set.
// (RULE12) Pattern chosen from area type, width, access size and low address.
module ebsd_strobe_ctrl
    import ebsd_pkg::*;
(
    input  wire logic                              mclk,
    input  wire logic                              nrst,
    input  wire logic                              acc_valid,
    input  wire ebsd_pkg::ebsd_space_e             acc_space,
    input  wire logic [2:0]                        acc_area,
    input  wire logic                              acc_write,
    input  wire ebsd_pkg::ebsd_size_e              acc_size,
    input  wire logic [ebsd_pkg::EBSD_ADDR_W-1:0]  acc_addr,
    input  wire logic [ebsd_pkg::EBSD_DATA_W-1:0]  acc_wdata,
    input  wire logic [15:0]                       space_mem_type,
    input  wire logic [15:0]                       space_bus_width,
    input  wire logic                              soft_standby,
    input  wire logic                              standby_float_outputs,
    input  wire logic                              standby_drive_control_pins,
    input  wire logic                              standby_drive_memory_pins,
    input  wire logic                              standby_drive_clock_pin,
    output logic [7:0]                             space_select_n,
    output logic                                   bus_cycle_strobe_n,
    output logic [1:0]                             row_strobe_n,
    output logic [1:0]                             column_strobe_n,
    output logic                                   data_mask_byte3,
    output logic                                   data_mask_byte2,
    output logic                                   data_mask_byte1,
    output logic                                   data_mask_byte0,
    output logic                                   address_latch_hold_n,
    output logic                                   read_write_dir,
    output logic                                   read_strobe_n,
    output logic                                   write_strobe_byte3_n,
    output logic                                   write_strobe_byte2_n,
    output logic                                   write_strobe_byte1_n,
    output logic                                   write_strobe_byte0_n,
    output logic [ebsd_pkg::EBSD_ADDR_W-1:0]       ext_addr,
    output logic [ebsd_pkg::EBSD_DATA_W-1:0]       ext_data_out,
    output logic [3:0]                             ext_data_oe,
    output logic                                   strobe_oe,
    output logic                                   memctl_oe,
    output logic                                   addr_oe,
    output logic                                   bus_clock_oe
);
    import ebsd_pkg::*;

    logic [7:0]             cs_r,    cs_nxt;
    logic                   bs_r,    bs_nxt;
    logic                   dir_r,   dir_nxt;
    logic                   rd_r,    rd_nxt;
    logic [3:0]             wr_r,    wr_nxt;
    logic [EBSD_ADDR_W-1:0] addr_r,  addr_nxt;
    logic [EBSD_DATA_W-1:0] dout_r,  dout_nxt;
    logic [3:0]             doe_r,   doe_nxt;
    logic                   sto_r,   sto_nxt;
    logic                   mco_r,   mco_nxt;
    logic                   ado_r,   ado_nxt;
    logic                   cko_r,   cko_nxt;
    logic                   idle_r,  idle_nxt;
    logic                   ext_acc;
    logic                   bytesel;
    logic [3:0]             lanes;
    ebsd_width_e            area_width;
    ebsd_memtype_e          area_type;

    // Area configuration of the addressed chip select
    assign area_width = ebsd_width_e'(ebsd_cfg_field(space_bus_width, acc_area));
    assign area_type  = ebsd_memtype_e'(ebsd_cfg_field(space_mem_type, acc_area));
    assign ext_acc    = acc_valid && (acc_space == EBSD_SP_EXT) && !soft_standby;
    assign bytesel    = (area_type == EBSD_MT_BYTESEL);

    ebsd_lane_decode u_lanes (
        .width   (area_width),
        .size    (acc_size),
        .addr_lo (acc_addr[1:0]),
        .lanes   (lanes)
    );

    // Strobe, address and data next values; idle unless an external access
    always_comb begin
        cs_nxt   = EBSD_CS_IDLE;                 // see RULE1
        bs_nxt   = EBSD_STROBE_IDLE;
        dir_nxt  = EBSD_STROBE_IDLE;
        rd_nxt   = EBSD_STROBE_IDLE;
        wr_nxt   = EBSD_LANES_ALL;
        doe_nxt  = EBSD_LANES_NONE;              // see RULE1
        dout_nxt = dout_r;
        addr_nxt = addr_r;                       // see RULE2
        if (ext_acc) begin
            cs_nxt   = ~(EBSD_CS_ONE << acc_area); // see RULE3
            bs_nxt   = 1'b0;                       // see RULE3
            dir_nxt  = !acc_write;                 // see RULE4
            rd_nxt   = acc_write;                  // see RULE4
            addr_nxt = acc_addr;
            // Byte-select SRAM strobes on reads too (see RULE8) (see RULE9)
            if (acc_write || bytesel) begin
                wr_nxt = ~lanes;                   // see RULE5 and RULE6
            end
            if (acc_write) begin
                doe_nxt  = lanes;                  // see RULE7
                dout_nxt = acc_wdata;
            end
        end
    end

    // Strobe group registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cs_r   <= EBSD_CS_IDLE;
            bs_r   <= EBSD_STROBE_IDLE;
            dir_r  <= EBSD_STROBE_IDLE;
            rd_r   <= EBSD_STROBE_IDLE;
            wr_r   <= EBSD_LANES_ALL;
            addr_r <= EBSD_ADDR_RST;
            dout_r <= EBSD_DATA_RST;
            doe_r  <= EBSD_LANES_NONE;
        end else begin
            cs_r   <= cs_nxt;
            bs_r   <= bs_nxt;
            dir_r  <= dir_nxt;
            rd_r   <= rd_nxt;
            wr_r   <= wr_nxt;
            addr_r <= addr_nxt;
            dout_r <= dout_nxt;
            doe_r  <= doe_nxt;
        end
    end

    // Pin enables; standby bits come from same-clock logic, no sync needed
    always_comb begin
        sto_nxt = !soft_standby || standby_drive_memory_pins;   // see RULE11
        mco_nxt = !soft_standby || standby_drive_control_pins;  // see RULE11
        cko_nxt = !soft_standby || standby_drive_clock_pin;     // see RULE11
        ado_nxt = !(soft_standby && standby_float_outputs);     // see RULE10
        idle_nxt = EBSD_STROBE_IDLE;                            // see RULE1
    end

    // Enable group registers; pins driven from reset on
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sto_r  <= EBSD_PIN_DRIVE;
            mco_r  <= EBSD_PIN_DRIVE;
            ado_r  <= EBSD_PIN_DRIVE;
            cko_r  <= EBSD_PIN_DRIVE;
            idle_r <= EBSD_STROBE_IDLE;
        end else begin
            sto_r  <= sto_nxt;
            mco_r  <= mco_nxt;
            ado_r  <= ado_nxt;
            cko_r  <= cko_nxt;
            idle_r <= idle_nxt;
        end
    end

    // Dynamic-memory pins never act here; one idle flop keeps them registered
    assign row_strobe_n         = {2{idle_r}};
    assign column_strobe_n      = {2{idle_r}};
    assign data_mask_byte3      = idle_r;
    assign data_mask_byte2      = idle_r;
    assign data_mask_byte1      = idle_r;
    assign data_mask_byte0      = idle_r;
    assign address_latch_hold_n = idle_r;

    // Registered pin outputs
    assign space_select_n       = cs_r;
    assign bus_cycle_strobe_n   = bs_r;
    assign read_write_dir       = dir_r;
    assign read_strobe_n        = rd_r;
    assign write_strobe_byte3_n = wr_r[3];
    assign write_strobe_byte2_n = wr_r[2];
    assign write_strobe_byte1_n = wr_r[1];
    assign write_strobe_byte0_n = wr_r[0];
    assign ext_addr             = addr_r;
    assign ext_data_out         = dout_r;
    assign ext_data_oe          = doe_r;
    assign strobe_oe            = sto_r;
    assign memctl_oe            = mco_r;
    assign addr_oe              = ado_r;
    assign bus_clock_oe         = cko_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_internal_quiet;
        acc_valid && acc_space != EBSD_SP_EXT |=> cs_r == EBSD_CS_IDLE && bs_r && rd_r
            && dir_r && wr_r == EBSD_LANES_ALL && doe_r == EBSD_LANES_NONE;
    endproperty
    a_internal_quiet: assert property (p_internal_quiet) else $error("internal access drove pins"); // see RULE1

    property p_addr_kept;
        acc_valid && acc_space != EBSD_SP_EXT |=> ext_addr == $past(ext_addr);
    endproperty
    a_addr_kept: assert property (p_addr_kept) else $error("address changed on internal access"); // see RULE2

    property p_cs_one;
        ext_acc |=> cs_r == ~(EBSD_CS_ONE << $past(acc_area)) && !bs_r;
    endproperty
    a_cs_one: assert property (p_cs_one) else $error("wrong chip select pattern"); // see RULE3

    property p_dir;
        ext_acc |=> (rd_r == $past(acc_write)) && (dir_r != $past(acc_write));
    endproperty
    a_dir: assert property (p_dir) else $error("read strobe or direction wrong"); // see RULE4

    property p_w8;
        ext_acc && acc_write && area_width == EBSD_BW_8 |=> wr_r == 4'hE && doe_r == 4'h1;
    endproperty
    a_w8: assert property (p_w8) else $error("8-bit write strobe wrong"); // see RULE5

    property p_w16_hi;
        ext_acc && acc_write && area_width == EBSD_BW_16 && acc_size == EBSD_SZ_BYTE
            && !acc_addr[0] |=> wr_r == 4'hD;
    endproperty
    a_w16_hi: assert property (p_w16_hi) else $error("16-bit high byte strobe wrong"); // see RULE5

    property p_w32_long;
        ext_acc && acc_write && area_width == EBSD_BW_32 && acc_size == EBSD_SZ_LONG
            |=> wr_r == 4'h0 ##1 wr_r == EBSD_LANES_ALL || $past(acc_valid);
    endproperty
    a_w32_long: assert property (p_w32_long) else $error("32-bit long write strobe wrong"); // see RULE6

    property p_normal_read;
        ext_acc && !acc_write && !bytesel |=> wr_r == EBSD_LANES_ALL && doe_r == EBSD_LANES_NONE;
    endproperty
    a_normal_read: assert property (p_normal_read) else $error("write strobe on normal read"); // see RULE6

    property p_lanes_only;
        ext_acc && acc_write |=> doe_r == ~wr_r;
    endproperty
    a_lanes_only: assert property (p_lanes_only) else $error("data on unaddressed lane"); // see RULE7

    property p_bytesel16;
        ext_acc && bytesel && area_width == EBSD_BW_16 && acc_size == EBSD_SZ_BYTE
            && acc_addr[0] |=> wr_r == 4'hE;
    endproperty
    a_bytesel16: assert property (p_bytesel16) else $error("16-bit byte select wrong"); // see RULE8

    property p_bytesel32;
        ext_acc && bytesel && area_width == EBSD_BW_32 && acc_size == EBSD_SZ_WORD
            && acc_addr[1] |=> wr_r == 4'hC;
    endproperty
    a_bytesel32: assert property (p_bytesel32) else $error("32-bit byte select wrong"); // see RULE9

    property p_float;
        soft_standby && standby_float_outputs |=> !addr_oe && doe_r == EBSD_LANES_NONE;
    endproperty
    a_float: assert property (p_float) else $error("outputs not floated in standby"); // see RULE10

    property p_drive;
        soft_standby |=> strobe_oe == $past(standby_drive_memory_pins)
            && memctl_oe == $past(standby_drive_control_pins);
    endproperty
    a_drive: assert property (p_drive) else $error("standby override not honoured"); // see RULE11
endmodule
`default_nettype wire

// [verification/ebsd_ext_model.sv]
// Far-side model: external memory data bus as attached devices see it.
// Assumes the controller is the only driver; this device only listens.
`timescale 1ns/1ps
`default_nettype none
module ebsd_ext_model (
    input  wire logic        mclk,
    input  wire logic [31:0] data_out,
    input  wire logic [3:0]  data_oe,
    input  wire logic [3:0]  wr_n,
    output wire logic [31:0] data_bus,
    output logic [31:0]      last_wr
);
    // No pull on this bus, so a released lane reads as floating
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign data_bus[8*i+:8] = data_oe[i] ? data_out[8*i+:8] : 8'hZZ;
    end

    // Byte taken while its strobe is low and the lane carries data;
    // byte-select reads lower the strobe too but leave the lane floating
    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (!wr_n[i] && data_oe[i]) begin
                last_wr[8*i+:8] <= data_bus[8*i+:8];
            end
        end
    end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the strobe decoder: driver notes, monitor compares.
// Assumes ebsd_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ebsd_pkg::*;
    typedef struct packed {
        logic [31:0] ctl;
        logic [25:0] adr;
        logic [31:0] bus;
    } ebsd_note_s;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        acc_valid = 1'b0;
    ebsd_space_e acc_space = EBSD_SP_ROM;
    logic [2:0]  acc_area = 3'h0;
    logic        acc_write = 1'b0;
    ebsd_size_e  acc_size = EBSD_SZ_BYTE;
    logic [25:0] acc_addr = 26'h0000000;
    logic [31:0] acc_wdata = 32'h00000000;
    logic [15:0] space_mem_type = 16'h0000;
    logic [15:0] space_bus_width = 16'h0000;
    logic        soft_standby = 1'b0;
    logic        standby_float_outputs = 1'b0;
    logic        standby_drive_control_pins = 1'b0;
    logic        standby_drive_memory_pins = 1'b0;
    logic        standby_drive_clock_pin = 1'b0;
    logic [7:0]  space_select_n;
    logic [1:0]  row_strobe_n, column_strobe_n;
    logic        bus_cycle_strobe_n, address_latch_hold_n, read_write_dir, read_strobe_n;
    logic        data_mask_byte3, data_mask_byte2, data_mask_byte1, data_mask_byte0;
    logic        write_strobe_byte3_n, write_strobe_byte2_n;
    logic        write_strobe_byte1_n, write_strobe_byte0_n;
    logic [25:0] ext_addr;
    logic [31:0] ext_data_out;
    logic [3:0]  ext_data_oe;
    logic        strobe_oe, memctl_oe, addr_oe, bus_clock_oe;
    wire  [31:0] data_bus;
    logic [31:0] pins_seen;
    logic [25:0] last_adr = 26'h0000000;
    logic        stby_on = 1'b0;
    ebsd_note_s  notes[$];
    ebsd_note_s  seen;
    ebsd_note_s  prev = '0;
    logic [31:0] wr_taken;
    int          n_mismatch = 0;
    int          checks_done = 0;

    ebsd_strobe_ctrl ebsd_strobe_ctrl_inst (.mclk, .nrst, .acc_valid, .acc_space, .acc_area,
        .acc_write, .acc_size, .acc_addr, .acc_wdata, .space_mem_type, .space_bus_width,
        .soft_standby, .standby_float_outputs, .standby_drive_control_pins,
        .standby_drive_memory_pins, .standby_drive_clock_pin, .space_select_n,
        .bus_cycle_strobe_n, .row_strobe_n, .column_strobe_n, .data_mask_byte3,
        .data_mask_byte2, .data_mask_byte1, .data_mask_byte0, .address_latch_hold_n,
        .read_write_dir, .read_strobe_n, .write_strobe_byte3_n, .write_strobe_byte2_n,
        .write_strobe_byte1_n, .write_strobe_byte0_n, .ext_addr, .ext_data_out,
        .ext_data_oe, .strobe_oe, .memctl_oe, .addr_oe, .bus_clock_oe);

    ebsd_ext_model ebsd_ext_model_inst (.mclk, .data_out(ext_data_out),
        .data_oe(ext_data_oe), .data_bus, .last_wr(wr_taken),
        .wr_n({write_strobe_byte3_n, write_strobe_byte2_n,
               write_strobe_byte1_n, write_strobe_byte0_n}));

    // Free-running bus clock, 40 ns period
    always #20 mclk = ~mclk;

    // All control pins in one word so one compare covers the pattern
    assign pins_seen = {space_select_n, bus_cycle_strobe_n, read_strobe_n, read_write_dir,
        write_strobe_byte3_n, write_strobe_byte2_n, write_strobe_byte1_n,
        write_strobe_byte0_n, row_strobe_n, column_strobe_n, data_mask_byte3,
        data_mask_byte2, data_mask_byte1, data_mask_byte0, address_latch_hold_n,
        strobe_oe, memctl_oe, addr_oe, bus_clock_oe, ext_data_oe};

    // Lanes a byte, word or longword occupies for each bus width
    function automatic logic [3:0] lane_pick(logic [1:0] bw, logic [1:0] s, logic [1:0] a);
        case (bw)
            2'h0: lane_pick = 4'h1;
            2'h1: lane_pick = (s != 2'h0) ? 4'h3 : (a[0] ? 4'h1 : 4'h2);
            2'h2: lane_pick = (s == 2'h2) ? 4'hF :
                              (s == 2'h1) ? (a[1] ? 4'h3 : 4'hC) : (4'h8 >> a);
            default: lane_pick = 4'h0;
        endcase
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One beat at the falling edge; the note is what the pins show half a cycle on, after the next rising edge
    task automatic go(input logic v, input logic [1:0] sp, input logic w, input logic [1:0] s,
                      input logic [25:0] a, input logic [1:0] mt, input logic [1:0] bw);
        ebsd_note_s n;
        logic [3:0] ln;
        logic       ext;
        logic       sb;
        if (s != 2'h0) a[0] = 1'b0;
        if (s == 2'h2) a[1] = 1'b0;
        @(negedge mclk);
        acc_valid = v;
        acc_space = ebsd_space_e'(sp);
        acc_write = w;
        acc_size = ebsd_size_e'(s);
        acc_addr = a;
        acc_area = 3'($urandom);
        acc_wdata = $urandom;
        space_mem_type[{acc_area, 1'b0} +: 2] = mt;
        space_bus_width[{acc_area, 1'b0} +: 2] = bw;
        soft_standby = stby_on & ($urandom % 4 == 0);
        {standby_float_outputs, standby_drive_control_pins,
         standby_drive_memory_pins, standby_drive_clock_pin} = 4'($urandom);
        sb = soft_standby;
        ext = v & !sb & (sp == 2'h3);
        ln = lane_pick(bw, s, a[1:0]);
        if (ext) last_adr = a;
        n.adr = last_adr;
        n.ctl[31:24] = ext ? ~(8'h01 << acc_area) : 8'hFF;
        n.ctl[23:21] = {!ext, !(ext & !w), !(ext & w)};
        n.ctl[20:17] = (ext && (mt == 2'h1 || w)) ? ~ln : 4'hF;
        n.ctl[16:8] = 9'h1FF;
        n.ctl[7:4] = {!sb | standby_drive_memory_pins, !sb | standby_drive_control_pins,
                      !(sb & standby_float_outputs), !sb | standby_drive_clock_pin};
        n.ctl[3:0] = (ext & w) ? ln : 4'h0;
        for (int i = 0; i < 4; i++) begin
            n.bus[8*i+:8] = n.ctl[i] ? acc_wdata[8*i+:8] : 8'hZZ;
        end
        notes.push_back(n);
    endtask

    // Monitor: once the edge's updates land, check the oldest note
    always @(posedge mclk) begin
        #1;
        // Bytes the far side took during the previous beat; a reset in between voids them
        for (int i = 0; i < 4; i++) begin
            if (nrst && prev.ctl[i]) begin
                chk("taken byte", {24'h000000, prev.bus[8*i+:8]}, {24'h000000, wr_taken[8*i+:8]});
            end
        end
        prev.ctl = 32'h00000000;
        if (notes.size() > 0) begin
            seen = notes.pop_front();
            prev = seen;
            chk("pins", seen.ctl, pins_seen);
            chk("address", {6'h00, seen.adr}, {6'h00, ext_addr});
            chk("data bus", seen.bus, data_bus);
        end
    end

    // Watchdog well beyond the roughly nine hundred cycles of stimulus
    initial begin
        repeat (3000) @(posedge mclk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        logic [1:0] bw;
        void'($urandom(32'hE98F));
        space_mem_type = 16'($urandom);
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        // Widths 8/16/32, normal and byte-select (not at 8 bits), byte/word/long, offsets 0-3, both directions, each chased by an internal access
        for (int b = 0; b < 3; b++) begin
            for (int m = 0; m < 2; m++) begin
                for (int s = 0; s < 3; s++) begin
                    for (int a = 0; a < 4; a++) begin
                        for (int w = 0; w < 2; w++) begin
                            if (!(m == 1 && b == 0)) begin
                                go(1'b1, 2'h3, 1'(w), 2'(s), {24'($urandom), 2'(a)},
                                   2'(m), 2'(b));
                                go(1'b1, 2'($urandom % 3), 1'(w), 2'h2, 26'($urandom),
                                   2'(m), 2'(b));
                            end
                        end
                    end
                end
            end
        end
        // Random traffic with standby and its override bits in play
        stby_on = 1'b1;
        repeat (600) begin
            bw = 2'($urandom); // Reserved width included: it must drive no lane
            go(1'($urandom % 4 != 0), 2'($urandom), 1'($urandom), 2'($urandom % 3),
               26'($urandom), (bw == 2'h0) ? 2'h0 : 2'($urandom), bw);
        end
        // Reset in mid-run; idle inputs so the unnoted edge stays quiet
        @(negedge mclk);
        acc_valid = 1'b0;
        nrst = 1'b0;
        last_adr = 26'h0000000;
        @(negedge mclk);
        nrst = 1'b1;
        stby_on = 1'b0;
        go(1'b1, 2'h1, 1'b1, 2'h2, 26'($urandom), 2'h0, 2'h2);
        repeat (40) begin
            bw = 2'($urandom % 3);
            go(1'b1, 2'($urandom), 1'($urandom), 2'($urandom % 3), 26'($urandom),
               (bw == 2'h0) ? 2'h0 : 2'($urandom), bw);
        end
        repeat (2) @(negedge mclk);
        report_and_stop();
    end
endmodule
`default_nettype wire
